// ==== hw/amp_ctrl_pkg.sv ====
package amp_ctrl_pkg;

   // ---------------------------------------------------------------
   // Clock and turn-on timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   // Turn-on time per nF of bias capacitor: 20 ms per 0.1 uF
   localparam int TON_NS_PER_NF = 200000;
   localparam int BYPASS_CAP_NF_DEF = 100;
   localparam int TON_CNT_W = 24;

   // ---------------------------------------------------------------
   // Control word layout and reset values
   // ---------------------------------------------------------------
   localparam int VOL_CODE_W = 5;
   localparam int ATTEN_W = 7;
   localparam logic CTRL_BIT_RST = 1'h0;
   localparam logic [VOL_CODE_W-1:0] VOL_CODE_RST = 5'h00;
   localparam logic [ATTEN_W-1:0] ATTEN_NONE = 7'h00;
   localparam logic [ATTEN_W-1:0] ATTEN_FLOOR = 7'h5A;
   localparam logic [VOL_CODE_W-1:0] VOL_CODE_MAX = 5'h1F;

   // Attenuation in dB (magnitude) per volume code, index 0 first
   localparam logic [ATTEN_W-1:0] VOL_ATTEN_DB [32] = '{
      7'h5A, 7'h5A, 7'h44, 7'h3F, 7'h39, 7'h33, 7'h2F, 7'h2D,
      7'h2A, 7'h27, 7'h24, 7'h22, 7'h20, 7'h1E, 7'h1C, 7'h1A,
      7'h18, 7'h16, 7'h14, 7'h12, 7'h10, 7'h0E, 7'h0C, 7'h0A,
      7'h08, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01, 7'h00
   };

   typedef enum logic [1:0] {
      TON_IDLE,
      TON_RAMP,
      TON_RUN
   } ton_state_e;

endpackage

// ==== hw/turn_on_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface turn_on_if;
   logic run;
   logic ramping;
   logic ready;

   modport seq (
      input run,
      output ramping,
      output ready
   );

   modport ctl (
      output run,
      input ramping,
      input ready
   );
endinterface

`default_nettype wire

// ==== hw/turn_on_seq.sv ====
`timescale 1ns/100ps
`default_nettype none

module turn_on_seq
   import amp_ctrl_pkg::*;
#(
   parameter int TURN_ON_CYCLES = 800000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Control side
   turn_on_if.seq ton
);

   // ---------------------------------------------------------------
   // Ramp timer
   // ---------------------------------------------------------------
   localparam logic [TON_CNT_W-1:0] TON_LAST = TON_CNT_W'(TURN_ON_CYCLES - 1);

   ton_state_e state_r;
   ton_state_e state_nxt;
   logic [TON_CNT_W-1:0] cnt_r;
   logic [TON_CNT_W-1:0] cnt_nxt;
   wire logic ramp_done;

   assign ramp_done = (cnt_r == TON_LAST);
   // Counter restarts on every entry, so a short shutdown still gets a full ramp
   assign cnt_nxt = (state_r == TON_RAMP) ? cnt_r + TON_CNT_W'(1) : '0;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         TON_IDLE: begin
            if (ton.run) begin
               state_nxt = TON_RAMP;
            end
         end
         TON_RAMP: begin
            if (!ton.run) begin
               state_nxt = TON_IDLE;
            end else if (ramp_done) begin
               state_nxt = TON_RUN;
            end
         end
         TON_RUN: begin
            if (!ton.run) begin
               state_nxt = TON_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= TON_IDLE;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign ton.ramping = (state_r == TON_RAMP);
   assign ton.ready = (state_r == TON_RUN);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   ramp_length_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_r == TON_RAMP && cnt_r == '0) ##1 (state_r == TON_RAMP)[*1]
      |-> (cnt_r == TON_CNT_W'(1)))
      else $error("turn-on counter did not advance");

endmodule

`default_nettype wire

// ==== hw/amp_control_bit_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

module amp_control_bit_decode
   import amp_ctrl_pkg::*;
#(
   parameter int BYPASS_CAP_NF = BYPASS_CAP_NF_DEF,
   parameter int TURN_ON_CYCLES = (BYPASS_CAP_NF * TON_NS_PER_NF) / CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Control word from the serial loader
   input wire logic ctrl_load,
   input wire logic shutdown_ctrl_bit,
   input wire logic mute_ctrl_bit,
   input wire logic volume_mode_bit,
   input wire logic gain_select_bit,
   input wire logic [VOL_CODE_W-1:0] volume_code,
   // Alert level comparator pin
   input wire logic alert_above_half,
   // Decoded amplifier controls
   output logic bias_en,
   output logic unity_gain_hold,
   output logic fully_operational,
   output logic amp_out_en,
   output logic dock_out_en,
   output logic fixed_gain_mode,
   output logic gain_internal,
   output logic [ATTEN_W-1:0] atten_db
);

   // ---------------------------------------------------------------
   // Control bit storage
   // ---------------------------------------------------------------
   logic shutdown_ctrl_bit_r;
   logic mute_ctrl_bit_r;
   logic volume_mode_bit_r;
   logic gain_select_bit_r;
   logic [VOL_CODE_W-1:0] volume_code_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         shutdown_ctrl_bit_r <= CTRL_BIT_RST;
         mute_ctrl_bit_r <= CTRL_BIT_RST;
         volume_mode_bit_r <= CTRL_BIT_RST;
         gain_select_bit_r <= CTRL_BIT_RST;
         volume_code_r <= VOL_CODE_RST;
      end else if (ctrl_load) begin
         shutdown_ctrl_bit_r <= shutdown_ctrl_bit;
         mute_ctrl_bit_r <= mute_ctrl_bit;
         volume_mode_bit_r <= volume_mode_bit;
         gain_select_bit_r <= gain_select_bit;
         volume_code_r <= volume_code;
      end
   end

   // ---------------------------------------------------------------
   // Alert pin synchroniser
   // ---------------------------------------------------------------
   logic alert_meta_r;
   logic alert_sync_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_meta_r <= 1'h0;
         alert_sync_r <= 1'h0;
      end else begin
         alert_meta_r <= alert_above_half;
         alert_sync_r <= alert_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Turn-on sequencer
   // ---------------------------------------------------------------
   turn_on_if ton ();

   assign ton.run = shutdown_ctrl_bit_r;

   turn_on_seq #(
      .TURN_ON_CYCLES(TURN_ON_CYCLES)
   ) u_turn_on (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ton(ton)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire logic active;
   wire logic alert_hit;
   wire logic bias_nxt;
   wire logic amp_nxt;
   wire logic dock_nxt;
   wire logic fixed_nxt;
   wire logic gain_int_nxt;
   wire logic [ATTEN_W-1:0] atten_nxt;

   // Alert is honoured only out of shutdown; the host must not drive it earlier
   assign active = shutdown_ctrl_bit_r;
   assign alert_hit = active & alert_sync_r;
   assign bias_nxt = active;
   // Alert pin only enables the stage; audio still comes via the stereo inputs
   assign amp_nxt = active & (~mute_ctrl_bit_r | alert_hit);
   assign dock_nxt = active & ~mute_ctrl_bit_r;
   assign fixed_nxt = ~volume_mode_bit_r;
   assign gain_int_nxt = ~gain_select_bit_r;
   assign atten_nxt = (!active || !volume_mode_bit_r) ? ATTEN_NONE
                      : VOL_ATTEN_DB[volume_code_r];

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   logic bias_en_r;
   logic amp_out_en_r;
   logic dock_out_en_r;
   logic fixed_gain_mode_r;
   logic gain_internal_r;
   logic [ATTEN_W-1:0] atten_db_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bias_en_r <= 1'h0;
         amp_out_en_r <= 1'h0;
         dock_out_en_r <= 1'h0;
         fixed_gain_mode_r <= 1'h1;
         gain_internal_r <= 1'h1;
         atten_db_r <= ATTEN_NONE;
      end else begin
         bias_en_r <= bias_nxt;
         amp_out_en_r <= amp_nxt;
         dock_out_en_r <= dock_nxt;
         fixed_gain_mode_r <= fixed_nxt;
         gain_internal_r <= gain_int_nxt;
         atten_db_r <= atten_nxt;
      end
   end

   assign bias_en = bias_en_r;
   assign amp_out_en = amp_out_en_r;
   assign dock_out_en = dock_out_en_r;
   assign fixed_gain_mode = fixed_gain_mode_r;
   assign gain_internal = gain_internal_r;
   assign atten_db = atten_db_r;
   assign unity_gain_hold = ton.ramping;
   assign fully_operational = ton.ready;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic loaded_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         loaded_r <= 1'h0;
      end else if (ctrl_load) begin
         loaded_r <= 1'h1;
      end
   end

   reset_shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !loaded_r |-> (!bias_en && !amp_out_en && !dock_out_en && !fully_operational))
      else $error("device left shutdown before any load");

   shutdown_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !shutdown_ctrl_bit_r |=> (!bias_en && !amp_out_en && !dock_out_en))
      else $error("output driven while shut down");

   bias_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ctrl_load && shutdown_ctrl_bit && !shutdown_ctrl_bit_r) |=> ##1 bias_en)
      else $error("bias not enabled after leaving shutdown");

   fixed_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !volume_mode_bit_r |=> (atten_db == ATTEN_NONE && fixed_gain_mode))
      else $error("volume code affected fixed-gain mode");

   volume_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (shutdown_ctrl_bit_r && volume_mode_bit_r && !ctrl_load)
      |=> (atten_db == VOL_ATTEN_DB[$past(volume_code_r)]))
      else $error("attenuation does not follow volume code");

   volume_ends_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (shutdown_ctrl_bit_r && volume_mode_bit_r && volume_code_r == VOL_CODE_MAX)
      |=> (atten_db == ATTEN_NONE || $past(ctrl_load)))
      else $error("top volume code not 0 dB");

   volume_floor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (shutdown_ctrl_bit_r && volume_mode_bit_r && volume_code_r[VOL_CODE_W-1:1] == '0)
      |=> (atten_db == ATTEN_FLOOR))
      else $error("lowest volume codes not at the floor");

   mute_dock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      mute_ctrl_bit_r |=> !dock_out_en)
      else $error("dock output live while muted");

   mute_amp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mute_ctrl_bit_r && !alert_sync_r) |=> !amp_out_en)
      else $error("amplifier output live while muted");

   alert_override_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (shutdown_ctrl_bit_r && mute_ctrl_bit_r && alert_sync_r) |=> amp_out_en)
      else $error("alert tone blocked by mute");

   alert_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      // Pin seen on three edges is in the output register after the third; the check reads it one edge later
      (shutdown_ctrl_bit_r && alert_above_half && !ctrl_load)[*3] |=> amp_out_en)
      else $error("alert did not enable bridge outputs");

   ramp_unity_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(shutdown_ctrl_bit_r) |=> (unity_gain_hold && !fully_operational))
      else $error("turn-on skipped the unity-gain ramp");

   gain_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      gain_select_bit_r |=> !gain_internal)
      else $error("internal gain kept with external select");

endmodule

`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_model
   import amp_ctrl_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Control word
   output logic ctrl_load,
   output logic shutdown_ctrl_bit,
   output logic mute_ctrl_bit,
   output logic volume_mode_bit,
   output logic gain_select_bit,
   output logic [VOL_CODE_W-1:0] volume_code,
   // Alert tone level
   output logic alert_above_half
);
   logic run_r;

   initial begin
      ctrl_load = 1'h0;
      {shutdown_ctrl_bit, mute_ctrl_bit, volume_mode_bit, gain_select_bit} = 4'h0;
      volume_code = 5'h00;
      alert_above_half = 1'h0;
      run_r = 1'h0;
   end

   // Caller sits at a clock edge; returns at the load edge
   task automatic send(input logic [8:0] w);
      ctrl_load <= 1'h1;
      {shutdown_ctrl_bit, mute_ctrl_bit, volume_mode_bit, gain_select_bit, volume_code} <= w;
      run_r <= w[8];
      @(posedge sys_clk);
   endtask

   task automatic idle();
      ctrl_load <= 1'h0;
   endtask

   // Tone held off until shutdown is cleared
   task automatic beep(input logic lvl);
      @(posedge sys_clk);
      alert_above_half <= lvl & run_r;
   endtask
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench
   import amp_ctrl_pkg::*;
;
   // Short ramp keeps the run small; the real count is a design parameter
   localparam int TON = 16;
   logic sys_clk = 1'h0;
   logic rst_b;
   logic ctrl_load, shut_bit, mu, vm, gs, alert;
   logic [VOL_CODE_W-1:0] code;
   logic bias_en, unity_gain_hold, fully_operational, amp_out_en, dock_out_en;
   logic fixed_gain_mode, gain_internal;
   logic [ATTEN_W-1:0] atten_db;
   logic [8:0] cur;
   int miscompares = 0;
   int total_checks = 0;
   int seed = 45;
   int r;

   always #12.5 sys_clk = ~sys_clk;

   host_model host_model_i (.sys_clk(sys_clk), .ctrl_load(ctrl_load), .shutdown_ctrl_bit(shut_bit),
      .mute_ctrl_bit(mu), .volume_mode_bit(vm), .gain_select_bit(gs), .volume_code(code),
      .alert_above_half(alert));

   amp_control_bit_decode #(.TURN_ON_CYCLES(TON)) amp_control_bit_decode_i (.sys_clk(sys_clk),
      .rst_b(rst_b), .ctrl_load(ctrl_load), .shutdown_ctrl_bit(shut_bit), .mute_ctrl_bit(mu),
      .volume_mode_bit(vm), .gain_select_bit(gs), .volume_code(code), .alert_above_half(alert),
      .bias_en(bias_en), .unity_gain_hold(unity_gain_hold), .fully_operational(fully_operational),
      .amp_out_en(amp_out_en), .dock_out_en(dock_out_en), .fixed_gain_mode(fixed_gain_mode),
      .gain_internal(gain_internal), .atten_db(atten_db));

   // ---------------------------------------------------------------
   // Checking
   // ---------------------------------------------------------------
   // Word layout: {shutdown, mute, mode, gain select, volume code}
   function automatic logic exp_dock(input logic [8:0] w);
      exp_dock = w[8] & ~w[7];
   endfunction

   // Alert lifts mute on the amplifier only
   function automatic logic exp_amp(input logic [8:0] w, input logic a);
      exp_amp = w[8] & (~w[7] | a);
   endfunction

   function automatic logic [ATTEN_W-1:0] exp_atten(input logic [8:0] w);
      exp_atten = (w[8] & w[6]) ? VOL_ATTEN_DB[w[4:0]] : ATTEN_NONE;
   endfunction

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_atten(input logic [ATTEN_W-1:0] exp, input logic [ATTEN_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD atten_db expected %h seen %h", exp, got);
      end
   endtask

   task automatic check_outs();
      cmp_bit("bias_en", cur[8], bias_en);
      cmp_bit("dock_out_en", exp_dock(cur), dock_out_en);
      cmp_bit("amp_out_en", exp_amp(cur, alert), amp_out_en);
      cmp_bit("fixed_gain_mode", ~cur[6], fixed_gain_mode);
      cmp_bit("gain_internal", ~cur[5], gain_internal);
      cmp_atten(exp_atten(cur), atten_db);
   endtask

   task automatic apply(input logic [8:0] w);
      @(posedge sys_clk);
      host_model_i.send(w);
      host_model_i.idle();
      cur = w;
      repeat (2) @(posedge sys_clk);
      #1;
      check_outs();
   endtask

   // Starts from shutdown; ramp length is fixed by the parameter
   task automatic ramp();
      @(posedge sys_clk);
      host_model_i.send(9'h13F);
      host_model_i.idle();
      cur = 9'h13F;
      // Ramp starts one edge after the load, so this lands on its last cycle
      repeat (TON) @(posedge sys_clk);
      #1;
      cmp_bit("unity_gain_hold", 1'h1, unity_gain_hold);
      cmp_bit("fully_operational", 1'h0, fully_operational);
      @(posedge sys_clk);
      #1;
      cmp_bit("unity_gain_hold", 1'h0, unity_gain_hold);
      cmp_bit("fully_operational", 1'h1, fully_operational);
      check_outs();
   endtask

   task automatic summarize();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      rst_b = 1'h0;
      cur = 9'h000;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'h1;
      @(posedge sys_clk);
      #1;
      check_outs();
      cmp_bit("fully_operational", 1'h0, fully_operational);
      ramp();
      for (int i = 0; i < 32; i++) begin
         apply({4'hA, 5'(i)});
      end
      apply(9'h15F);
      cmp_atten(7'h00, atten_db);
      apply(9'h141);
      cmp_atten(7'h5A, atten_db);
      // Random words, shutdown among them
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         apply(r[8:0]);
      end
      // Back-to-back loads: only the second may show
      @(posedge sys_clk);
      host_model_i.send(9'h05F);
      host_model_i.send(9'h16A);
      host_model_i.idle();
      cur = 9'h16A;
      repeat (2) @(posedge sys_clk);
      #1;
      check_outs();
      apply(9'h000);
      ramp();
      // Alert while muted reaches the amplifier, not the dock
      apply(9'h180);
      host_model_i.beep(1'h1);
      repeat (4) @(posedge sys_clk);
      #1;
      check_outs();
      host_model_i.beep(1'h0);
      repeat (4) @(posedge sys_clk);
      #1;
      check_outs();
      // Reset in mid-run falls back to shutdown; held bits are not reloaded
      @(posedge sys_clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'h1;
      cur = 9'h000;
      @(posedge sys_clk);
      #1;
      check_outs();
      cmp_bit("fully_operational", 1'h0, fully_operational);
      summarize();
   end

   // Hang guard
   initial begin
      #500000;
      miscompares++;
      summarize();
   end
endmodule

`default_nettype wire
